//--- rtl/bausp_top.sv
// Summary of operation
// - Shift register write starts a byte only if enable was already set.
// - CPU buffer RAM accesses never wait; serial unit RAM accesses are delayed while CPU uses memory.
// - Auto transmit/receive stores each received byte, then gap, then fetches next.
// - Gap length comes from interval register plus strobe and busy enables.
// - CPU RAM collisions may delay the store before the gap and the fetch after it, not the gap.
// - Auto transmit-only runs the gap after each byte, then fetches next byte.
// - Repeat mode reads RAM after each byte; read follows the gap.
// - Sleep during a byte suspends the transfer.
// - Wake resumes the suspended byte from exactly where it stopped.
// - Strobe and busy enables still give a gap with interval zero.
// - Start and stop triggers self-clear at done of an auto transfer; stop acts only when the gap after a byte ends.
module bausp_top (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // Register port
    input  wire logic [bausp_pkg::AW-1:0] regAddr,
    input  wire logic [bausp_pkg::DW-1:0] regWdata,
    input  wire logic                     regWr,
    input  wire logic                     regRd,
    output logic      [bausp_pkg::DW-1:0] regRdata,
    // CPU state
    input  wire logic                     cpuSleep,
    // Serial link
    input  wire logic                     sckIn,
    input  wire logic                     serialIn,
    input  wire logic                     busyIn,
    output logic                          serialOut,
    output logic                          strobeOut,
    // Status
    output logic                          transferInProgress,
    output logic                          transferDone
);
    typedef struct packed {
        logic                      modeEn;
        bausp_pkg::bausp_mode_t    mode;
        logic                      stbEn;
        logic                      busyEn;
        logic                      tsf;
        logic                      trigStart;
        logic                      trigStop;
        logic [bausp_pkg::RAW-1:0] endPtr;
        logic [bausp_pkg::DW-1:0]  ival;
        logic [bausp_pkg::DW-1:0]  shifter;
        logic                      so;
        logic                      stb;
        logic                      done;
        logic [bausp_pkg::DW-1:0]  rdata;
        bausp_pkg::bausp_state_t   state;
        logic [2:0]                bitCnt;
        logic [bausp_pkg::RAW-1:0] idx;
        logic [8:0]                gapCnt;
        logic                      sckS1;
        logic                      sckS2;
        logic                      sckD;
        logic                      siS1;
        logic                      siS2;
        logic                      busyS1;
        logic                      busyS2;
    } bausp_st_t;

    bausp_st_t                s_r;
    bausp_st_t                s_nxt;
    logic                     sckRise;
    logic                     sckFall;
    logic                     ramWin;
    logic [bausp_pkg::DW-1:0] cpuRamRdata;
    logic                     bufInReady;
    logic                     bufOutValid;
    logic [bausp_pkg::DW-1:0] bufOutData;
    logic                     lastByte;
    logic                     gapOver;

    bausp_ram_if ramBus ();

    // Register address match
    function automatic logic hit(input logic [bausp_pkg::AW-1:0] a,
                                 input logic [bausp_pkg::AW-1:0] off);
        hit = a == off;
    endfunction

    // Gap length: interval plus strobe time when strobe enabled
    function automatic logic [8:0] gapLoad(input logic [7:0] iv,
                                           input logic       stbE);
        gapLoad = {1'b0, iv} + (stbE ? bausp_pkg::STROBE_CYC : 9'h000);
    endfunction

    // Link clock edges from the synchronised copy
    assign sckRise  = s_r.sckS2 & ~s_r.sckD;
    assign sckFall  = ~s_r.sckS2 & s_r.sckD;
    assign ramWin   = regAddr[bausp_pkg::RAM_SEL_BIT];
    assign lastByte = s_r.idx == s_r.endPtr;
    assign gapOver  = (s_r.gapCnt == 9'h000) & ~(s_r.busyEn & s_r.busyS2);

    // Serial unit requests on the buffer RAM
    assign ramBus.req   = (s_r.state == bausp_pkg::ST_FETCH & bufInReady)
                        | (s_r.state == bausp_pkg::ST_STORE
                           & s_r.mode == bausp_pkg::BAUSP_AUTO_TRX);
    assign ramBus.we    = s_r.state == bausp_pkg::ST_STORE;
    assign ramBus.addr  = s_r.idx;
    assign ramBus.wdata = s_r.shifter;

    // Outputs straight from state
    assign regRdata           = s_r.rdata;
    assign serialOut          = s_r.so;
    assign strobeOut          = s_r.stb;
    assign transferInProgress = s_r.tsf;
    assign transferDone       = s_r.done;

    // Buffer RAM, CPU side never waits
    bausp_ram u_ram (
        .clk      (clk),
        .rst      (rst),
        .cpuWe    (regWr & ramWin),
        .cpuRe    (regRd & ramWin),
        .cpuAddr  (regAddr[bausp_pkg::RAW-1:0]),
        .cpuWdata (regWdata),
        .cpuRdata (cpuRamRdata),
        .ser      (ramBus.mem)
    );

    // Two-entry buffer between RAM fetch and shifter
    bausp_buf u_buf (
        .clk      (clk),
        .rst      (rst),
        .inValid  (ramBus.rvalid),
        .inReady  (bufInReady),
        .inData   (ramBus.rdata),
        .outValid (bufOutValid),
        .outReady (s_r.state == bausp_pkg::ST_LOAD),
        .outData  (bufOutData)
    );

    // Next state: synchronisers, register port, sequencer
    always_comb
    begin
        s_nxt        = s_r;
        s_nxt.done   = 1'b0;
        s_nxt.sckS1  = sckIn;
        s_nxt.sckS2  = s_r.sckS1;
        s_nxt.sckD   = s_r.sckS2;
        s_nxt.siS1   = serialIn;
        s_nxt.siS2   = s_r.siS1;
        s_nxt.busyS1 = busyIn;
        s_nxt.busyS2 = s_r.busyS1;
        s_nxt.stb    = s_r.state == bausp_pkg::ST_GAP & s_r.stbEn
                     & (s_r.gapCnt > {1'b0, s_r.ival});

        // Register reads, data one cycle later
        if (regRd)
        begin
            if (ramWin)
                s_nxt.rdata = cpuRamRdata;
            else if (hit(regAddr, bausp_pkg::ADDR_MODE))
                s_nxt.rdata = {s_r.modeEn, 5'h00, s_r.mode};
            else if (hit(regAddr, bausp_pkg::ADDR_STATUS))
                s_nxt.rdata = {2'h0, s_r.stbEn, s_r.busyEn, 3'h0, s_r.tsf};
            else if (hit(regAddr, bausp_pkg::ADDR_TRIG))
                s_nxt.rdata = {6'h00, s_r.trigStop, s_r.trigStart};
            else if (hit(regAddr, bausp_pkg::ADDR_ENDPTR))
                s_nxt.rdata = {3'h0, s_r.endPtr};
            else if (hit(regAddr, bausp_pkg::ADDR_IVAL))
                s_nxt.rdata = s_r.ival;
            else if (hit(regAddr, bausp_pkg::ADDR_SHIFT))
                s_nxt.rdata = s_r.shifter;
            else
                s_nxt.rdata = 8'h00;
        end

        // Register writes
        if (regWr & ~ramWin)
        begin
            if (hit(regAddr, bausp_pkg::ADDR_MODE))
            begin
                s_nxt.modeEn = regWdata[bausp_pkg::MODE_EN_BIT];
                s_nxt.mode   = bausp_pkg::bausp_mode_t'(regWdata[1:0]);
            end
            else if (hit(regAddr, bausp_pkg::ADDR_STATUS))
            begin
                s_nxt.stbEn  = regWdata[bausp_pkg::STB_EN_BIT];
                s_nxt.busyEn = regWdata[bausp_pkg::BUSY_EN_BIT];
            end
            else if (hit(regAddr, bausp_pkg::ADDR_TRIG))
            begin
                // Stop is latched and honoured only when the gap after a byte ends
                if (s_r.tsf & regWdata[bausp_pkg::TRIG_STOP_BIT])
                    s_nxt.trigStop = 1'b1;
                if (regWdata[bausp_pkg::TRIG_START_BIT] & s_r.modeEn
                    & s_r.mode != bausp_pkg::BAUSP_SINGLE
                    & s_r.state == bausp_pkg::ST_IDLE)
                begin
                    s_nxt.trigStart = 1'b1;
                    s_nxt.tsf       = 1'b1;
                    s_nxt.idx       = '0;
                    s_nxt.state     = bausp_pkg::ST_FETCH;
                end
            end
            else if (hit(regAddr, bausp_pkg::ADDR_ENDPTR))
                s_nxt.endPtr = regWdata[bausp_pkg::RAW-1:0];
            else if (hit(regAddr, bausp_pkg::ADDR_IVAL))
                s_nxt.ival = regWdata;
            else if (hit(regAddr, bausp_pkg::ADDR_SHIFT))
            begin
                s_nxt.shifter = regWdata;
                // Starts only when enable was set beforehand
                if (s_r.modeEn & s_r.mode == bausp_pkg::BAUSP_SINGLE
                    & s_r.state == bausp_pkg::ST_IDLE)
                begin
                    s_nxt.tsf    = 1'b1;
                    s_nxt.so     = regWdata[bausp_pkg::DW-1];
                    s_nxt.bitCnt = 3'h0;
                    s_nxt.state  = bausp_pkg::ST_SHIFT;
                end
            end
        end

        // Transfer sequencer
        case (s_r.state)
            bausp_pkg::ST_FETCH:
            begin
                // Fetch waits on buffer room and on CPU priority
                if (ramBus.gnt)
                    s_nxt.state = bausp_pkg::ST_LOAD;
            end
            bausp_pkg::ST_LOAD:
            begin
                if (bufOutValid)
                begin
                    s_nxt.shifter = bufOutData;
                    s_nxt.so      = bufOutData[bausp_pkg::DW-1];
                    s_nxt.bitCnt  = 3'h0;
                    s_nxt.state   = bausp_pkg::ST_SHIFT;
                end
            end
            bausp_pkg::ST_SHIFT:
            begin
                // Sleep freezes shifter and count in place
                if (!cpuSleep)
                begin
                    if (sckFall)
                        s_nxt.so = s_r.shifter[bausp_pkg::DW-1];
                    if (sckRise)
                    begin
                        s_nxt.shifter = {s_r.shifter[bausp_pkg::DW-2:0],
                                         s_r.siS2};
                        s_nxt.bitCnt  = s_r.bitCnt + 3'h1;
                        if (s_r.bitCnt == bausp_pkg::LAST_BIT)
                        begin
                            if (s_r.mode == bausp_pkg::BAUSP_SINGLE)
                            begin
                                s_nxt.tsf   = 1'b0;
                                s_nxt.done  = 1'b1;
                                s_nxt.state = bausp_pkg::ST_IDLE;
                            end
                            else
                                s_nxt.state = bausp_pkg::ST_STORE;
                        end
                    end
                end
            end
            bausp_pkg::ST_STORE:
            begin
                // Received byte written back in transmit/receive mode; CPU access delays it
                if (s_r.mode != bausp_pkg::BAUSP_AUTO_TRX | ramBus.gnt)
                begin
                    s_nxt.gapCnt = gapLoad(s_r.ival, s_r.stbEn);
                    s_nxt.state  = bausp_pkg::ST_GAP;
                end
            end
            bausp_pkg::ST_GAP:
            begin
                // Count interval, then hold while peer busy
                if (s_r.gapCnt != 9'h000)
                    s_nxt.gapCnt = s_r.gapCnt - 9'h001;
                else if (gapOver)
                begin
                    if (s_r.trigStop | (lastByte
                        & s_r.mode != bausp_pkg::BAUSP_REPEAT))
                    begin
                        s_nxt.tsf       = 1'b0;
                        s_nxt.done      = 1'b1;
                        s_nxt.trigStart = 1'b0;
                        s_nxt.trigStop  = 1'b0;
                        s_nxt.state     = bausp_pkg::ST_IDLE;
                    end
                    else
                    begin
                        s_nxt.idx   = lastByte ? '0 : s_r.idx + 5'h01;
                        s_nxt.state = bausp_pkg::ST_FETCH;
                    end
                end
            end
            default:
            begin
            end
        endcase

        // Output idles low whenever no transfer runs
        if (!s_nxt.tsf)
            s_nxt.so = 1'b0;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_r        <= '0;
            s_r.ival   <= bausp_pkg::IVAL_RST;
            s_r.endPtr <= bausp_pkg::ENDPTR_RST;
            s_r.sckS1  <= 1'b1; // Link clock idles high, no false edge
            s_r.sckS2  <= 1'b1;
            s_r.sckD   <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_single_start: assert property (
        regWr & hit(regAddr, bausp_pkg::ADDR_SHIFT) & ~ramWin & s_r.modeEn
        & s_r.mode == bausp_pkg::BAUSP_SINGLE & ~s_r.tsf
        |=> s_r.tsf ##0 s_r.state == bausp_pkg::ST_SHIFT)
        else $error("single byte did not start");
    a_late_enable: assert property (
        regWr & hit(regAddr, bausp_pkg::ADDR_SHIFT) & ~ramWin & ~s_r.modeEn
        & ~s_r.tsf |=> ~s_r.tsf [*2])
        else $error("transfer started without enable");
    a_store_after: assert property (
        s_r.state == bausp_pkg::ST_SHIFT & ~cpuSleep & sckRise
        & s_r.bitCnt == bausp_pkg::LAST_BIT
        & s_r.mode != bausp_pkg::BAUSP_SINGLE
        |=> s_r.state == bausp_pkg::ST_STORE)
        else $error("byte end did not reach store");
    a_gap_length: assert property (
        s_r.state == bausp_pkg::ST_STORE ##1 s_r.state == bausp_pkg::ST_GAP
        |-> s_r.gapCnt == gapLoad(s_r.ival, s_r.stbEn))
        else $error("gap loaded with wrong length");
    a_zero_ival: assert property (
        s_r.state == bausp_pkg::ST_GAP & s_r.stbEn & s_r.ival == 8'h00
        & $past(s_r.state) == bausp_pkg::ST_STORE
        |-> s_r.gapCnt == bausp_pkg::STROBE_CYC)
        else $error("strobe gap missing at zero interval");
    a_store_stall: assert property (
        s_r.state == bausp_pkg::ST_STORE & regWr & ramWin
        & s_r.mode == bausp_pkg::BAUSP_AUTO_TRX
        |=> s_r.state == bausp_pkg::ST_STORE)
        else $error("store bypassed CPU priority");
    a_gap_fetch: assert property (
        s_r.state == bausp_pkg::ST_GAP & gapOver & ~s_r.trigStop
        & ~lastByte |=> s_r.state == bausp_pkg::ST_FETCH
        ##0 s_r.idx == $past(s_r.idx) + 5'h01)
        else $error("next byte not fetched");
    a_repeat_wrap: assert property (
        s_r.state == bausp_pkg::ST_GAP & gapOver & ~s_r.trigStop & lastByte
        & s_r.mode == bausp_pkg::BAUSP_REPEAT
        |=> s_r.idx == 5'h00 ##0 s_r.state == bausp_pkg::ST_FETCH)
        else $error("repeat did not wrap");
    a_sleep_hold: assert property (
        s_r.state == bausp_pkg::ST_SHIFT & cpuSleep
        |=> $stable(s_r.shifter) & $stable(s_r.bitCnt))
        else $error("shift moved during sleep");
    a_sleep_resume: assert property (
        s_r.state == bausp_pkg::ST_SHIFT & cpuSleep
        |=> s_r.state == bausp_pkg::ST_SHIFT & s_r.tsf)
        else $error("suspended byte was abandoned");
    a_trig_clear: assert property (
        s_r.done & s_r.mode != bausp_pkg::BAUSP_SINGLE
        |-> ~s_r.trigStart & ~s_r.trigStop & ~s_r.tsf)
        else $error("triggers not cleared at done");

    c_single: cover property (s_r.done & s_r.mode == bausp_pkg::BAUSP_SINGLE);
    c_auto_end: cover property (s_r.done
                                & s_r.mode == bausp_pkg::BAUSP_AUTO_TRX);
    c_repeat: cover property (s_r.state == bausp_pkg::ST_FETCH
                              & s_r.mode == bausp_pkg::BAUSP_REPEAT
                              & s_r.idx == 5'h00 & s_r.trigStart);
    c_sleep: cover property (s_r.state == bausp_pkg::ST_SHIFT & cpuSleep);
endmodule // bausp_top

//--- rtl/bausp_pkg.sv
package bausp_pkg;

    // Bus and memory geometry
    localparam int DW       = 8;
    localparam int AW       = 6;
    localparam int RAW      = 5;
    localparam int RAM_WORDS = 32;
    localparam int BUF_DEPTH = 2;

    // Register offsets
    localparam logic [AW-1:0] ADDR_MODE    = 6'h00; // Serial mode register
    localparam logic [AW-1:0] ADDR_STATUS  = 6'h01; // Serial status register
    localparam logic [AW-1:0] ADDR_TRIG    = 6'h02; // Auto start/stop triggers
    localparam logic [AW-1:0] ADDR_ENDPTR  = 6'h03; // Buffer end pointer
    localparam logic [AW-1:0] ADDR_IVAL    = 6'h04; // Inter-byte interval
    localparam logic [AW-1:0] ADDR_SHIFT   = 6'h05; // Serial shift register
    localparam int            RAM_SEL_BIT  = 5;     // Set: buffer RAM window

    // Field positions
    localparam int MODE_EN_BIT    = 7;
    localparam int STB_EN_BIT     = 5;
    localparam int BUSY_EN_BIT    = 4;
    localparam int TSF_BIT        = 0;
    localparam int TRIG_START_BIT = 0;
    localparam int TRIG_STOP_BIT  = 1;

    // Reset values
    localparam logic [DW-1:0]  IVAL_RST   = 8'h00;
    localparam logic [RAW-1:0] ENDPTR_RST = 5'h00;

    // Strobe pulse length and its cycle count at the system clock
    localparam int CLK_MHZ   = 50;
    localparam int STROBE_NS = 100;
    localparam logic [8:0] STROBE_CYC =
        9'((STROBE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [2:0] LAST_BIT = 3'h7;

    // Operating modes
    typedef enum logic [1:0] {
        BAUSP_SINGLE   = 2'h0,
        BAUSP_AUTO_TRX = 2'h1,
        BAUSP_AUTO_TX  = 2'h2,
        BAUSP_REPEAT   = 2'h3
    } bausp_mode_t;

    // Sequencer states, Gray from idle through to gap
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_FETCH = 3'h1,
        ST_LOAD  = 3'h3,
        ST_SHIFT = 3'h2,
        ST_STORE = 3'h6,
        ST_GAP   = 3'h7
    } bausp_state_t;

endpackage

//--- rtl/bausp_ram_if.sv
interface bausp_ram_if;
    logic                      req;
    logic                      we;
    logic [bausp_pkg::RAW-1:0] addr;
    logic [bausp_pkg::DW-1:0]  wdata;
    logic                      gnt;
    logic [bausp_pkg::DW-1:0]  rdata;
    logic                      rvalid;

    modport unit (output req, we, addr, wdata, input gnt, rdata, rvalid);
    modport mem  (input req, we, addr, wdata, output gnt, rdata, rvalid);
endinterface

//--- rtl/bausp_ram.sv
module bausp_ram (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    // CPU port, served at once
    input  wire logic                      cpuWe,
    input  wire logic                      cpuRe,
    input  wire logic [bausp_pkg::RAW-1:0] cpuAddr,
    input  wire logic [bausp_pkg::DW-1:0]  cpuWdata,
    output logic      [bausp_pkg::DW-1:0]  cpuRdata,
    // Serial unit port
    bausp_ram_if.mem                       ser
);
    typedef struct packed {
        logic [bausp_pkg::DW-1:0] rdata;
        logic                     rvalid;
    } bausp_ram_st_t;

    logic [bausp_pkg::DW-1:0] mem [bausp_pkg::RAM_WORDS];
    bausp_ram_st_t            s_r;
    bausp_ram_st_t            s_nxt;
    logic                     cpuAct;

    // CPU wins a same-cycle conflict, serial access waits
    assign cpuAct    = cpuWe | cpuRe;
    assign ser.gnt   = ser.req & ~cpuAct;
    assign cpuRdata  = mem[cpuAddr];
    assign ser.rdata = s_r.rdata;
    assign ser.rvalid = s_r.rvalid;

    // Serial read data one cycle after grant
    always_comb
    begin
        s_nxt        = s_r;
        s_nxt.rvalid = ser.gnt & ~ser.we;
        if (ser.gnt & ~ser.we)
        begin
            s_nxt.rdata = mem[ser.addr];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Array writes, no reset on storage
    always_ff @(posedge clk)
    begin
        if (cpuWe)
        begin
            mem[cpuAddr] <= cpuWdata;
        end
        else if (ser.gnt & ser.we)
        begin
            mem[ser.addr] <= ser.wdata;
        end
    end

    a_cpu_first: assert property (@(posedge clk) disable iff (rst)
        cpuAct |-> !ser.gnt)
        else $error("serial grant during CPU access");
endmodule // bausp_ram

//--- rtl/bausp_buf.sv
module bausp_buf (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst,
    // Filling side
    input  wire logic                     inValid,
    output logic                          inReady,
    input  wire logic [bausp_pkg::DW-1:0] inData,
    // Draining side
    output logic                          outValid,
    input  wire logic                     outReady,
    output logic      [bausp_pkg::DW-1:0] outData
);
    typedef struct packed {
        logic [bausp_pkg::BUF_DEPTH-1:0][bausp_pkg::DW-1:0] data;
        logic [1:0]                                          count;
        logic                                                wrPtr;
        logic                                                rdPtr;
    } bausp_buf_st_t;

    bausp_buf_st_t s_r;
    bausp_buf_st_t s_nxt;
    logic          push;
    logic          pop;

    // Honest full and empty flags
    assign inReady  = s_r.count != 2'h2;
    assign outValid = s_r.count != 2'h0;
    assign outData  = s_r.data[s_r.rdPtr];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    always_comb
    begin
        s_nxt = s_r;
        if (push)
        begin
            s_nxt.data[s_r.wrPtr] = inData;
            s_nxt.wrPtr           = ~s_r.wrPtr;
        end
        if (pop)
        begin
            s_nxt.rdPtr = ~s_r.rdPtr;
        end
        s_nxt.count = s_r.count + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end
endmodule // bausp_buf

//--- tb/bausp_peer.sv
module bausp_peer (
    // Link pins
    input  wire logic serialOut,
    output logic      sckIn,
    output logic      serialIn,
    // Pause marker for the bench
    output logic      inPause
);
    timeunit 1ns;
    timeprecision 1ns;

    // Clock idles high and stands still between frames
    initial {sckIn, serialIn, inPause} = 3'h4;

    // One byte MSB first at 160 ns; junk edges while paused
    task automatic xfer(logic [7:0] tx, int junk, output logic [7:0] rx);
        #7; // Keep pin edges off the system clock edge
        for (int i = 7; i >= 0; i--)
        begin
            if (i == 3 && junk > 0)
            begin
                inPause = 1'b1;
                #400 repeat (junk) #80 sckIn = ~sckIn;
                #400 inPause = 1'b0;
                #200;
            end
            {sckIn, serialIn} = {1'b0, tx[i]};
            #80 sckIn = 1'b1;
            rx[i] = serialOut;
            #80;
        end
        serialIn = ~serialIn; // Released line drops the last bit
    endtask
endmodule // bausp_peer

//--- tb/bausp_top_tb.sv
module bausp_top_tb;
    timeunit 1ns;
    timeprecision 1ns;

    // Bench signals
    logic       clk, rst, regWr, regRd, cpuSleep, pause, tip, done;
    logic       busy = 1'b0;
    logic       sckIn, serialIn, serialOut, strobeOut;
    logic [5:0] regAddr;
    logic [7:0] regWdata, regRdata, rx;
    logic [7:0] expRam [2] = '{8'h96, 8'h5A};
    int         errCount, nChecks, cyc, stbCnt, nDone;

    // Block and far-side peer
    bausp_top DUT (.clk, .rst, .regAddr, .regWdata, .regWr, .regRd,
        .regRdata, .cpuSleep, .sckIn, .serialIn, .busyIn(busy), .serialOut,
        .strobeOut, .transferInProgress(tip), .transferDone(done));
    bausp_peer peer (.serialOut, .sckIn, .serialIn, .inPause(pause));

    // System clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Sleep follows the pause; strobes, done pulses and time counted
    always @(posedge clk)
    begin
        cpuSleep <= pause;
        stbCnt <= stbCnt + int'(strobeOut === 1'b1);
        nDone <= nDone + int'(done === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 20000) finishTest(1);
    end

    // Compare and count
    task automatic check(string what, logic [7:0] got, logic [7:0] exp);
        nChecks++;
        errCount += int'(got !== exp);
        if (got !== exp)
            $display("BAD %s expected %h seen %h", what, exp, got);
    endtask

    // Register write, then read with compare
    task automatic wr(logic [5:0] a, logic [7:0] d);
        @(posedge clk) {regWr, regAddr, regWdata} <= {1'b1, a, d};
        @(posedge clk) regWr <= 1'b0;
    endtask
    task automatic rdChk(string what, logic [5:0] a, logic [7:0] exp);
        @(posedge clk) {regRd, regAddr} <= {1'b1, a};
        @(posedge clk) regRd <= 1'b0;
        #1 check(what, regRdata, exp);
    endtask

    // Auto sequence: sleep in byte 0, stop before the last repeat byte
    task automatic runAuto(logic [7:0] mode, int n, int doneN);
        int s0;
        s0 = stbCnt;
        wr(6'h00, mode);
        wr(6'h02, 8'h01);
        for (int i = 0; i < n; i++)
        begin
            repeat (30) @(posedge clk);
            if (i == n - 1 && mode == 8'h83) wr(6'h02, 8'h02);
            if (i == n - 1 && mode == 8'h82) busy <= 1'b1;
            if (i == 0) wr(6'h25, 8'h77);
            peer.xfer(8'h40 + 8'(i), i == 0 ? 4 : 0, rx);
            check("tx", rx, expRam[i % 2]);
        end
        // Busy peer holds the last gap open
        if (mode == 8'h82)
        begin
            repeat (60) @(posedge clk);
            check("busy hold", 8'(nDone), 8'(doneN - 1));
            busy <= 1'b0;
        end
        repeat (400) if (nDone < doneN) @(posedge clk);
        check("done", 8'(nDone), 8'(doneN));
        rdChk("trig", 6'h02, 8'h00);
        check("strobes", 8'(stbCnt - s0), 8'(5 * n));
        rdChk("cpu ram", 6'h25, 8'h77);
    endtask

    // Reset, then the scenarios in turn
    initial
    begin
        {rst, regWr, regRd, regAddr, regWdata} = {3'h4, 14'h0};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rdChk("interval", 6'h04, 8'h00);
        rdChk("unmapped", 6'h10, 8'h00);
        wr(6'h05, 8'hA5);
        wr(6'h00, 8'h80);
        repeat (20) @(posedge clk);
        #1 check("no start", {7'h0, tip}, 8'h00);
        wr(6'h05, 8'h3C);
        repeat (3) @(posedge clk);
        #1 check("start", {7'h0, tip}, 8'h01);
        peer.xfer(8'hC3, 0, rx);
        check("single tx", rx, 8'h3C);
        repeat (20) @(posedge clk);
        rdChk("single rx", 6'h05, 8'hC3);
        wr(6'h20, 8'h96);
        wr(6'h21, 8'h5A);
        wr(6'h03, 8'h01);
        wr(6'h01, 8'h20);
        runAuto(8'h81, 2, 2);
        rdChk("rx ram 0", 6'h20, 8'h40);
        rdChk("rx ram 1", 6'h21, 8'h41);
        expRam = '{8'h40, 8'h41};
        wr(6'h01, 8'h30);
        runAuto(8'h82, 2, 3);
        runAuto(8'h83, 3, 4);
        finishTest(0);
    end

    // Verdict and end of run
    task automatic finishTest(int extra);
        errCount += extra;
        $display("Checks %0d, mismatches %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
endmodule // bausp_top_tb
